// File: rcc_defines.vh
// Constants for reset strap capture and core clock configuration
// Function
// - Boot straps: 00 SPI slave, 01 SPI master, 10 parallel EPROM
// - Ratio straps: 00 3:1, 01 16:1, 10 8:1
// - During reset multiplier comes from ratio straps
// - Oscillator equals twice multiplier times loop input
// - Core clock is oscillator over twice post divider
// - Post divider is one during reset
// - Input halving enable halves reference into loop
// - Core, memory, serial, parallel use core clock
// - Serial bit clocks divide core clock per port
// - Software may retune multiplier and divider once the core runs; writes before lock leave the strap setting in use
// - Wait 4096 reference cycles for lock, then run
`ifndef RCC_DEFINES_VH
`define RCC_DEFINES_VH
// Register byte addresses
`define RCC_ADDR_POWER_CLOCK_CONTROL_REG        4'h0
`define RCC_ADDR_STATUS       4'h4
`define RCC_ADDR_SDIV0        4'h8
`define RCC_ADDR_SDIV1        4'hC
// Power and clock control fields
`define RCC_PM_MULT_LSB       0
`define RCC_PM_MULT_MSB       5
`define RCC_PM_DIV_LSB        6
`define RCC_PM_DIV_MSB        7
`define RCC_PM_HALVE_BIT      8
`define RCC_PM_RESET          32'h0000_0000
// Status fields
`define RCC_ST_BOOT_LSB       0
`define RCC_ST_RATIO_LSB      2
`define RCC_ST_BOOT_BAD_BIT   4
`define RCC_ST_RATIO_BAD_BIT  5
`define RCC_ST_LOCKED_BIT     6
`define RCC_ST_PROG_BIT       7
// Serial divider reset value
`define RCC_SDIV_RESET        16'h0000
// Strap encodings
`define RCC_BOOT_SPI_SLAVE    2'h0
`define RCC_BOOT_SPI_MASTER   2'h1
`define RCC_BOOT_PARALLEL     2'h2
`define RCC_RATIO_3           2'h0
`define RCC_RATIO_16          2'h1
`define RCC_RATIO_8           2'h2
`define RCC_RESERVED_CODE     2'h3
`define RCC_MULT_3            6'h03
`define RCC_MULT_16           6'h10
`define RCC_MULT_8            6'h08
// Timing: reference cycles to lock, sync depth before strap capture
`define RCC_LOCK_REF_CYCLES   4096
`define RCC_SYNC_FILL         2'h3
// Credit fraction: one core cycle is this many credit units
`define RCC_CREDIT_UNIT       16'h0020
`define RCC_CREDIT_SHIFT      5
// Bus responses
`define RCC_RESP_OKAY         2'h0
`define RCC_RESP_SLVERR       2'h2
`endif

// File: rcc_serial_div.v
// Serial bit clock divider running on core clock ticks
`timescale 1ns/1ps
`include "rcc_defines.vh"
module rcc_serial_div
(
	// Clock and reset
	input  wire        mclk,
	input  wire        rst_n,
	// Core tick and divide setting
	input  wire        core_tick,
	input  wire [15:0] div_val,
	// Bit clock outputs
	output reg         bit_tick_q,
	output reg         bit_clk_q
);
	reg [15:0] cnt_q;

	// Zero divide stops the port clock
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q      <= 16'h0000;
			bit_tick_q <= 1'b0;
			bit_clk_q  <= 1'b0;
		end
		else
		begin
			bit_tick_q <= 1'b0;
			if (div_val == 16'h0000)
				cnt_q <= 16'h0000;
			else if (core_tick)
			begin
				if (cnt_q >= div_val - 16'h0001)
				begin
					cnt_q      <= 16'h0000;
					bit_tick_q <= 1'b1;
					bit_clk_q  <= ~bit_clk_q;
				end
				else
					cnt_q <= cnt_q + 16'h0001;
			end
		end
	end
endmodule

// File: rcc_core.v
// Strap capture, loop lock wait, core clock synthesis and register slave
`timescale 1ns/1ps
`include "rcc_defines.vh"
module rcc_core
#(
	parameter LOCK_REF_CYCLES = `RCC_LOCK_REF_CYCLES
)
(
	// Clock and reset
	input  wire        mclk,
	input  wire        rst_n,
	// Board pins
	input  wire [1:0]  boot_select_straps,
	input  wire [1:0]  clock_ratio_straps,
	input  wire        reference_clock_in,
	// AXI4-Lite write address
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Clocking and boot outputs
	output reg         core_cycle_clock,
	output reg         core_run,
	output reg  [1:0]  boot_mode,
	output reg         boot_invalid,
	output reg         ratio_invalid,
	output wire [1:0]  serial_bit_clock,
	output wire [1:0]  serial_bit_tick
);
	// Strap ratio to startup multiplier
	function [5:0] ratio_mult;
		input [1:0] code;
		begin
			case (code)
				`RCC_RATIO_3:  ratio_mult = `RCC_MULT_3;
				`RCC_RATIO_16: ratio_mult = `RCC_MULT_16;
				`RCC_RATIO_8:  ratio_mult = `RCC_MULT_8;
				default:       ratio_mult = `RCC_MULT_3;
			endcase
		end
	endfunction

	// Byte-enable merge for register writes
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = data[i*8 +: 8];
		end
	endfunction

	reg [2:0]  boot_s0_q, boot_s1_q, boot_s2_q;
	reg [1:0]  ratio_s1_q, ratio_s2_q, ratio_s0_q;
	reg        ref_s0_q, ref_s1_q, ref_s2_q, ref_lvl_q;
	reg [1:0]  fill_q;
	reg        captured_q;
	reg [1:0]  ratio_cap_q;
	reg [12:0] lock_cnt_q;
	reg [31:0] power_clock_control_reg_q;
	reg        prog_q;
	reg [15:0] sdiv0_q, sdiv1_q;
	reg [15:0] credit_q;
	reg        aw_have_q, w_have_q;
	reg [3:0]  awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0]  wstrb_q;
	reg        ref_rise;
	reg [5:0]  mult_eff;
	reg [2:0]  shift_eff;
	reg [15:0] add_val;
	reg [16:0] credit_sum;
	reg [31:0] status_val;
	reg [31:0] rd_val;
	reg        rd_ok;
	reg [31:0] sdiv_new;

	// Pin synchronisers; only stages two and three are compared
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			boot_s0_q  <= 3'h0;
			boot_s1_q  <= 3'h0;
			boot_s2_q  <= 3'h0;
			ratio_s0_q <= 2'h0;
			ratio_s1_q <= 2'h0;
			ratio_s2_q <= 2'h0;
			ref_s0_q   <= 1'b0;
			ref_s1_q   <= 1'b0;
			ref_s2_q   <= 1'b0;
			ref_lvl_q  <= 1'b0;
		end
		else
		begin
			boot_s0_q  <= {1'b0, boot_select_straps};
			boot_s1_q  <= boot_s0_q;
			boot_s2_q  <= boot_s1_q;
			ratio_s0_q <= clock_ratio_straps;
			ratio_s1_q <= ratio_s0_q;
			ratio_s2_q <= ratio_s1_q;
			ref_s0_q   <= reference_clock_in;
			ref_s1_q   <= ref_s0_q;
			ref_s2_q   <= ref_s1_q;
			if (ref_s1_q == ref_s2_q)
				ref_lvl_q <= ref_s2_q;
		end
	end

	always @*
	begin
		ref_rise = (ref_s1_q == ref_s2_q) && ref_s2_q && !ref_lvl_q;
	end

	// Straps latched once the pipe has filled after release; pins ignored after
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fill_q        <= 2'h0;
			captured_q    <= 1'b0;
			ratio_cap_q   <= 2'h0;
			boot_mode     <= 2'h0;
			boot_invalid  <= 1'b0;
			ratio_invalid <= 1'b0;
		end
		else if (!captured_q)
		begin
			if (fill_q != `RCC_SYNC_FILL)
				fill_q <= fill_q + 2'h1;
			else if (boot_s1_q == boot_s2_q && ratio_s1_q == ratio_s2_q)
			begin
				captured_q    <= 1'b1;
				ratio_cap_q   <= ratio_s2_q;
				boot_mode     <= boot_s2_q[1:0];
				boot_invalid  <= (boot_s2_q[1:0] == `RCC_RESERVED_CODE);
				ratio_invalid <= (ratio_s2_q == `RCC_RESERVED_CODE);
			end
		end
	end

	// Effective loop setting: straps and divide-by-one until software retunes
	always @*
	begin
		if (prog_q)
		begin
			mult_eff  = power_clock_control_reg_q[`RCC_PM_MULT_MSB:`RCC_PM_MULT_LSB];
			shift_eff = {1'b0, power_clock_control_reg_q[`RCC_PM_DIV_MSB:`RCC_PM_DIV_LSB]} + 3'h1
				+ {2'h0, power_clock_control_reg_q[`RCC_PM_HALVE_BIT]};
		end
		else
		begin
			mult_eff  = ratio_mult(ratio_cap_q);
			shift_eff = 3'h0;
		end
		// Core cycles per reference cycle = mult / 2^shift_eff (shift is div + 1 + halve once retuned), in 1/32 units
		add_val    = {10'h000, mult_eff} << (`RCC_CREDIT_SHIFT - shift_eff);
		credit_sum = {1'b0, credit_q} + (ref_rise ? {1'b0, add_val} : 17'h00000);
	end

	// Lock wait counted in reference cycles, then core released
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lock_cnt_q <= 13'h0000;
			core_run   <= 1'b0;
		end
		else if (captured_q && !core_run && ref_rise)
		begin
			if (lock_cnt_q == LOCK_REF_CYCLES[12:0] - 13'h0001)
				core_run <= 1'b1;
			else
				lock_cnt_q <= lock_cnt_q + 13'h0001;
		end
	end

	// Core tick synthesis; saturation guards a reference faster than mclk allows
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			credit_q         <= 16'h0000;
			core_cycle_clock <= 1'b0;
		end
		else if (!core_run)
		begin
			credit_q         <= 16'h0000;
			core_cycle_clock <= 1'b0;
		end
		else
		begin
			core_cycle_clock <= (credit_sum >= {1'b0, `RCC_CREDIT_UNIT});
			if (credit_sum >= {1'b0, `RCC_CREDIT_UNIT})
				credit_q <= credit_sum[16] ? 16'hFFFF : credit_sum[15:0] - `RCC_CREDIT_UNIT;
			else
				credit_q <= credit_sum[15:0];
		end
	end

	// Serial ports clocked from core ticks
	rcc_serial_div u_sdiv0
	(
		.mclk       (mclk),
		.rst_n      (rst_n),
		.core_tick  (core_cycle_clock),
		.div_val    (sdiv0_q),
		.bit_tick_q (serial_bit_tick[0]),
		.bit_clk_q  (serial_bit_clock[0])
	);

	rcc_serial_div u_sdiv1
	(
		.mclk       (mclk),
		.rst_n      (rst_n),
		.core_tick  (core_cycle_clock),
		.div_val    (sdiv1_q),
		.bit_tick_q (serial_bit_tick[1]),
		.bit_clk_q  (serial_bit_clock[1])
	);

	// Write channel; address and data taken in either order
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RCC_RESP_OKAY;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			awaddr_q      <= 4'h0;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
			power_clock_control_reg_q       <= `RCC_PM_RESET;
			prog_q        <= 1'b0;
			sdiv0_q       <= `RCC_SDIV_RESET;
			sdiv1_q       <= `RCC_SDIV_RESET;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_q     <= 1'b1;
				awaddr_q      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_q     <= 1'b1;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (aw_have_q && w_have_q && !s_axi_bvalid)
			begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `RCC_RESP_OKAY;
				case (awaddr_q & 4'hC)
					`RCC_ADDR_POWER_CLOCK_CONTROL_REG:
					begin
						power_clock_control_reg_q <= merge(power_clock_control_reg_q, wdata_q, wstrb_q) & 32'h0000_01FF;
						prog_q  <= core_run;
					end
					`RCC_ADDR_SDIV0: sdiv0_q <= sdiv_new[15:0];
					`RCC_ADDR_SDIV1: sdiv1_q <= sdiv_new[15:0];
					default: s_axi_bresp <= `RCC_RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always @*
	begin
		// Upper half takes write data bytes 2 and 3, which are dropped when cut to the field
		sdiv_new   = merge({16'h0000, awaddr_q[2] ? sdiv1_q : sdiv0_q}, wdata_q, wstrb_q);
		status_val = 32'h0000_0000;
		status_val[`RCC_ST_BOOT_LSB +: 2]  = boot_mode;
		status_val[`RCC_ST_RATIO_LSB +: 2] = ratio_cap_q;
		status_val[`RCC_ST_BOOT_BAD_BIT]   = boot_invalid;
		status_val[`RCC_ST_RATIO_BAD_BIT]  = ratio_invalid;
		status_val[`RCC_ST_LOCKED_BIT]     = core_run;
		status_val[`RCC_ST_PROG_BIT]       = prog_q;
		rd_ok = 1'b1;
		case (s_axi_araddr & 4'hC)
			`RCC_ADDR_POWER_CLOCK_CONTROL_REG:
				rd_val = {23'h000000, power_clock_control_reg_q[`RCC_PM_HALVE_BIT],
					power_clock_control_reg_q[`RCC_PM_DIV_MSB:`RCC_PM_DIV_LSB], mult_eff};
			`RCC_ADDR_STATUS: rd_val = status_val;
			`RCC_ADDR_SDIV0:  rd_val = {16'h0000, sdiv0_q};
			`RCC_ADDR_SDIV1:  rd_val = {16'h0000, sdiv1_q};
			default:
			begin
				rd_val = 32'h0000_0000;
				rd_ok  = 1'b0;
			end
		endcase
	end

	// Read channel; data registered at the address handshake
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RCC_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_val;
			s_axi_rresp   <= rd_ok ? `RCC_RESP_OKAY : `RCC_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule

// File: rcc_core_sva.sv
// Checker for strap capture, lock wait, serial ticks and read answers
`timescale 1ns/1ps
module rcc_core_sva
#(
	parameter LOCK_REF_CYCLES = 4096
)
(
	// Clock and reset
	input wire        mclk,
	input wire        rst_n,
	// Reference pin and read channel
	input wire        reference_clock_in,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	// Status outputs
	input wire        core_run,
	input wire [1:0]  boot_mode,
	input wire        boot_invalid,
	input wire        ratio_invalid,
	input wire [1:0]  serial_bit_clock,
	input wire [1:0]  serial_bit_tick
);
	reg        ref_q;
	reg [15:0] refs_q;
	// Counts from release, so it may run one edge ahead of the design
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ref_q <= 1'b0;
			refs_q <= 16'h0000;
		end
		else
		begin
			ref_q <= reference_clock_in;
			if (reference_clock_in && !ref_q && !core_run)
				refs_q <= refs_q + 16'h0001;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence ar_taken; s_axi_arvalid && s_axi_arready; endsequence
	sequence r_answer; s_axi_rvalid && !s_axi_arready; endsequence
	a_boot_flag: assert property (core_run |-> boot_invalid == (boot_mode == 2'h3))
		else $error("boot flag wrong");
	a_boot_hold: assert property ($past(core_run) |-> $stable(boot_mode))
		else $error("boot mode moved");
	a_ratio_hold: assert property ($past(core_run) |-> $stable(ratio_invalid))
		else $error("ratio flag moved");
	a_run_stays: assert property (core_run |=> core_run)
		else $error("run dropped");
	a_lock_wait: assert property ($rose(core_run) |-> refs_q >= LOCK_REF_CYCLES && refs_q <= LOCK_REF_CYCLES + 2)
		else $error("lock wait length wrong");
	a_tick_clk0: assert property (serial_bit_tick[0] == $changed(serial_bit_clock[0]))
		else $error("port 0 tick and clock differ");
	a_tick_clk1: assert property (serial_bit_tick[1] == $changed(serial_bit_clock[1]))
		else $error("port 1 tick and clock differ");
	a_read_answer: assert property (ar_taken |=> r_answer)
		else $error("read answer late");
endmodule
bind rcc_core rcc_core_sva #(.LOCK_REF_CYCLES(LOCK_REF_CYCLES)) u_sva (.mclk(mclk), .rst_n(rst_n),
	.reference_clock_in(reference_clock_in), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .core_run(core_run), .boot_mode(boot_mode), .boot_invalid(boot_invalid),
	.ratio_invalid(ratio_invalid), .serial_bit_clock(serial_bit_clock), .serial_bit_tick(serial_bit_tick));

// File: rcc_board.sv
// Board model: strap pins and reference clock source
`timescale 1ns/1ps
module rcc_board
#(
	parameter HALF = 20
)
(
	// Clock and requested strap levels
	input wire        mclk,
	input wire [1:0]  boot_set,
	input wire [1:0]  ratio_set,
	// Board pins
	output reg [1:0]  boot_select_straps = 2'h0,
	output reg [1:0]  clock_ratio_straps = 2'h0,
	output reg        reference_clock_in = 1'b0
);
	integer cnt_q = 0;
	// Reference never halts; straps reach the pins one clock after the request, whether or not reset is held
	always @(posedge mclk)
	begin
		boot_select_straps <= boot_set;
		clock_ratio_straps <= ratio_set;
		cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
		if (cnt_q == HALF - 1)
			reference_clock_in <= ~reference_clock_in;
	end
endmodule

// File: rcc_core_test.sv
// Self-checking bench for strap capture and core clock synthesis
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("FAIL %0t got %0h exp %0h", $time, g, e); end end
module rcc_core_test;
	logic        mclk = 0, rst_n = 0, av = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic [1:0]  bset = 0, rset = 0, bs, cs, bresp, rresp, bm, sclk, stick, rsp;
	logic        refc, awr, wr_, bv, arr, rv, ccc, run, binv, rinv;
	logic [3:0]  aa = 0, ra = 0;
	logic [31:0] wd = 0, rdata, rd;
	int          error_cnt = 0, check_count = 0, cyc = 0, cc = 0, t0 = 0, t1 = 0, n;
	localparam logic [23:0] MT = {6'h03, 6'h08, 6'h10, 6'h03};
	localparam logic [8:0]  PV [5] = '{9'h008, 9'h048, 9'h110, 9'h090, 9'h0D0};
	localparam int          PE [5] = '{4, 2, 4, 2, 1};
	always #5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cc <= cc + ccc;
		t0 <= t0 + stick[0];
		t1 <= t1 + stick[1];
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			end_sim;
		end
	end
	rcc_board #(.HALF(20)) board (.mclk(mclk), .boot_set(bset), .ratio_set(rset), .boot_select_straps(bs),
		.clock_ratio_straps(cs), .reference_clock_in(refc));
	rcc_core #(.LOCK_REF_CYCLES(8)) DUT (.mclk(mclk), .rst_n(rst_n), .boot_select_straps(bs),
		.clock_ratio_straps(cs), .reference_clock_in(refc), .s_axi_awaddr(aa), .s_axi_awvalid(av),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ra), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.core_cycle_clock(ccc), .core_run(run), .boot_mode(bm), .boot_invalid(binv), .ratio_invalid(rinv),
		.serial_bit_clock(sclk), .serial_bit_tick(stick));
	task wr(input logic [3:0] a, input logic [31:0] d);
		logic ga, gw, gb;
		@(posedge mclk);
		aa <= a;
		wd <= d;
		av <= 1;
		wv <= 1;
		br <= 1;
		gb = 0;
		while (!gb)
		begin
			@(negedge mclk);
			ga = awr & av;
			gw = wr_ & wv;
			gb = bv;
			rsp = bresp;
			@(posedge mclk);
			if (ga) av <= 0;
			if (gw) wv <= 0;
			if (gb) br <= 0;
		end
	endtask
	task rdr(input logic [3:0] a);
		logic ga, gr;
		@(posedge mclk);
		ra <= a;
		arv <= 1;
		rr <= 1;
		gr = 0;
		while (!gr)
		begin
			@(negedge mclk);
			ga = arr & arv;
			gr = rv;
			rd = rdata;
			rsp = rresp;
			@(posedge mclk);
			if (ga) arv <= 0;
			if (gr) rr <= 0;
		end
	endtask
	// Whole bursts fall between reference rises, so counts are exact
	task meas(input int m, input int e0, input int e1);
		int c, a, b;
		repeat (2) @(posedge refc);
		#1;
		c = cc;
		a = t0;
		b = t1;
		repeat (4) @(posedge refc);
		#1;
		`CHK(cc - c, 4 * m)
		`CHK(t0 - a, e0)
		`CHK(t1 - b, e1)
	endtask
	task rst(input logic [1:0] b, input logic [1:0] r);
		@(posedge mclk);
		rst_n <= 0;
		bset <= b;
		rset <= r;
		repeat (12) @(posedge mclk);
		rst_n <= 1;
		repeat (20) @(posedge mclk);
		bset <= ~b;
		rset <= ~r;
		n = 0;
		while (run !== 1'b1 && n < 900)
		begin
			@(posedge mclk);
			n++;
		end
		`CHK(n >= 260 && n < 900, 1'b1)
	endtask
	task t_straps;
		for (int i = 0; i < 4; i++)
		begin
			rst(i[1:0], i[1:0]);
			`CHK(bm, i[1:0])
			`CHK({binv, rinv}, {2{i == 3}})
			rdr(4'h4);
			`CHK(rd, {24'h0, 2'b01, {2{i == 3}}, i[1:0], i[1:0]})
			rdr(4'h0);
			`CHK(rd[5:0], MT[i * 6 +: 6])
			meas(MT[i * 6 +: 6], 0, 0);
		end
		$display("test straps done");
	endtask
	task t_prog;
		for (int k = 0; k < 5; k++)
		begin
			wr(4'h0, {23'h0, PV[k]});
			`CHK(rsp, 2'h0)
			rdr(4'h0);
			`CHK(rd, {23'h0, PV[k]})
			meas(PE[k], 0, 0);
		end
		rdr(4'h4);
		`CHK(rd[7:6], 2'b11)
		$display("test program done");
	endtask
	task t_serial;
		wr(4'h8, 32'h2);
		wr(4'hC, 32'h4);
		wr(4'h0, 32'h10);
		meas(8, 16, 8);
		rdr(4'h8);
		`CHK(rd, 32'h2)
		`CHK(rsp, 2'h0)
		wr(4'h4, 32'h0);
		`CHK(rsp, 2'h2)
		rdr(4'h4);
		`CHK(rd, 32'hFF)
		$display("test serial done");
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		t_straps;
		t_prog;
		t_serial;
		end_sim;
	end
endmodule
